/* File: core/asc_cfg.svh */
// Overview of operation
// - Channel codes 0 to 12 pick inputs; 13 to 15 pick nothing.
// - Run bit reads one while converting, zero when idle.
// - Enable bit switches the converter on and off.
// - Unused control bits read zero and ignore writes.
// - Acquisition code gives 0,2,4,6,8,12,16,20 conversion-clock periods.
// - RC conversion clock adds one instruction cycle before clocking.
// - Software picks supply rails or external pins as reference.
// - Only the RC conversion clock keeps converting through Sleep.
// - Result comes from successive approximation, most significant first.
// - Each conversion gives a 12-bit unsigned value.
// - Reset restores registers, turns converter off, aborts conversion.
// - Completion loads result, clears run bit, sets done flag.
// - Zero acquisition code holds conversion off one instruction cycle.
// - Clearing run bit aborts; result keeps last completed value.
// - After completion or abort wait two cycles, then sample.
// - Compare trigger sets run bit when enabled, ignored when disabled.
`ifndef ASC_CFG_SVH
`define ASC_CFG_SVH

// ***************************************************
// Register offsets
// ***************************************************
`define ASC_OFS_CTRL 8'h00
`define ASC_OFS_TIMING 8'h04
`define ASC_OFS_RESH 8'h08
`define ASC_OFS_RESL 8'h0c
`define ASC_OFS_REF 8'h10
`define ASC_OFS_STAT 8'h14

// ***************************************************
// Field positions and codes
// ***************************************************
`define ASC_CTRL_EN 0
`define ASC_CTRL_GO 1
`define ASC_CHS_LSB 2
`define ASC_TIM_FMT 7
`define ASC_ACQ_LSB 3
`define ASC_CS_LSB 0
`define ASC_REF_EXT 0
`define ASC_STAT_DONE 0
`define ASC_CHAN_MAX 4'hc
`define ASC_TRIG_MODE 4'hb
`define ASC_RC_CODE 2'h3
`define ASC_SAR_MSB 12'h800

// ***************************************************
// Reset values
// ***************************************************
`define ASC_CTRL_RST 8'h00
`define ASC_TIMING_RST 8'h00
`define ASC_RESULT_RST 16'h0000

// ***************************************************
// Timing
// ***************************************************
`define ASC_CLK_MHZ 100
`define ASC_TCY_NS 40
`define ASC_TCY_CLKS ((`ASC_TCY_NS * `ASC_CLK_MHZ + 999) / 1000)
`define ASC_POST_TCY 2

`endif

/* File: core/asc_pkg.sv */
package asc_pkg;

   typedef enum logic [2:0] {
      ASC_IDLE,
      ASC_HOLD,
      ASC_ACQ,
      ASC_CONV,
      ASC_WAIT
   } asc_state_t;

   typedef enum logic [2:0] {
      ASC_SEL_CTRL,
      ASC_SEL_TIMING,
      ASC_SEL_RESH,
      ASC_SEL_RESL,
      ASC_SEL_REF,
      ASC_SEL_STAT,
      ASC_SEL_NONE
   } asc_sel_t;

   typedef struct packed {
      logic [3:0] channel;
      logic channelValid;
      logic sampleOn;
      logic refExternal;
      logic [11:0] trialCode;
   } asc_afe_t;

endpackage

/* File: core/asc_tad_gen.sv */
`timescale 1ns/10ps
`default_nettype none
`include "asc_cfg.svh"

module asc_tad_gen
   import asc_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic run,
   input wire logic [2:0] clkSel,
   input wire logic rcOscIn,
   output logic tadTick
);

   // ***************************************************
   // Divider decode
   // ***************************************************
   function automatic logic [6:0] divOf(input logic [2:0] sel);
      case (sel)
         3'h0: divOf = 7'h02;
         3'h1: divOf = 7'h08;
         3'h2: divOf = 7'h20;
         3'h4: divOf = 7'h04;
         3'h5: divOf = 7'h10;
         3'h6: divOf = 7'h40;
         default: divOf = 7'h00;
      endcase
   endfunction

   logic [2:0] rcSync_q;
   logic [2:0] rcSync_d;
   logic rcStable_q;
   logic rcStable_d;
   logic [6:0] cnt_q;
   logic [6:0] cnt_d;
   logic tick_q;
   logic tick_d;
   logic useRc;

   // ***************************************************
   // Next state
   // ***************************************************
   always_comb begin
      useRc = (clkSel[1:0] == `ASC_RC_CODE);
      rcSync_d = {rcSync_q[1:0], rcOscIn};
      // Edge counts only once stages two and three agree
      rcStable_d = (rcSync_q[1] == rcSync_q[2]) ? rcSync_q[2] : rcStable_q;
      cnt_d = cnt_q;
      tick_d = 1'b0;
      if (!run) begin
         cnt_d = 7'h00;
      end else if (useRc) begin
         tick_d = rcStable_d && !rcStable_q;
      end else if (cnt_q == 7'(divOf(clkSel) - 7'h01)) begin
         cnt_d = 7'h00;
         tick_d = 1'b1;
      end else begin
         cnt_d = 7'(cnt_q + 7'h01);
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rcSync_q <= 3'h0;
         rcStable_q <= 1'b0;
         cnt_q <= 7'h00;
         tick_q <= 1'b0;
      end else begin
         rcSync_q <= rcSync_d;
         rcStable_q <= rcStable_d;
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign tadTick = tick_q;

endmodule
`default_nettype wire

/* File: core/asc_adc_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
`include "asc_cfg.svh"

module asc_adc_ctrl
   import asc_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic compIn,
   input wire logic rcOscIn,
   input wire logic specialTrig,
   input wire logic [3:0] compareMode,
   input wire logic sleepMode,
   output asc_afe_t afeCtrl,
   output logic doneFlag
);

   localparam logic [3:0] TCY_LAST = 4'(`ASC_TCY_CLKS - 1);
   localparam logic [3:0] POST_LAST = 4'(`ASC_POST_TCY * `ASC_TCY_CLKS - 1);

   // ***************************************************
   // Decode helpers
   // ***************************************************
   function automatic asc_sel_t decodeReg(input logic [7:0] a);
      if (a == `ASC_OFS_CTRL) begin
         decodeReg = ASC_SEL_CTRL;
      end else if (a == `ASC_OFS_TIMING) begin
         decodeReg = ASC_SEL_TIMING;
      end else if (a == `ASC_OFS_RESH) begin
         decodeReg = ASC_SEL_RESH;
      end else if (a == `ASC_OFS_RESL) begin
         decodeReg = ASC_SEL_RESL;
      end else if (a == `ASC_OFS_REF) begin
         decodeReg = ASC_SEL_REF;
      end else if (a == `ASC_OFS_STAT) begin
         decodeReg = ASC_SEL_STAT;
      end else begin
         decodeReg = ASC_SEL_NONE;
      end
   endfunction

   function automatic logic [4:0] acqPeriods(input logic [2:0] code);
      case (code)
         3'h0: acqPeriods = 5'h00;
         3'h1: acqPeriods = 5'h02;
         3'h2: acqPeriods = 5'h04;
         3'h3: acqPeriods = 5'h06;
         3'h4: acqPeriods = 5'h08;
         3'h5: acqPeriods = 5'h0c;
         3'h6: acqPeriods = 5'h10;
         default: acqPeriods = 5'h14;
      endcase
   endfunction

   asc_state_t state_q, state_d;
   logic en_q, en_d;
   logic go_q, go_d;
   logic [3:0] chs_q, chs_d;
   logic fmt_q, fmt_d;
   logic [2:0] acq_q, acq_d;
   logic [2:0] cs_q, cs_d;
   logic refExt_q, refExt_d;
   logic [15:0] result_q, result_d;
   logic flag_q, flag_d;
   logic [11:0] sar_q, sar_d;
   logic [3:0] bit_q, bit_d;
   logic [4:0] cnt_q, cnt_d;
   asc_afe_t afe_q, afe_d;
   logic [31:0] prdata_q, prdata_d;
   logic [2:0] cmpSync_q, cmpSync_d;
   logic cmp_q, cmp_d;
   asc_sel_t sel;
   logic apbWr;
   logic enNow;
   logic rcSel;
   logic startReq;
   logic abort;
   logic convDone;
   logic tadRun;
   logic tadTick;
   logic [11:0] sarFinal;

   // ***************************************************
   // Bus slave
   // ***************************************************
   // Zero wait states; read data is captured in the setup cycle
   assign pready = 1'b1;
   assign sel = decodeReg(paddr);
   assign apbWr = psel && penable && pwrite;
   assign pslverr = psel && penable && (sel == ASC_SEL_NONE);

   always_comb begin
      prdata_d = prdata_q;
      if (psel && !penable) begin
         prdata_d = 32'h0000_0000;
         if (sel == ASC_SEL_CTRL) begin
            prdata_d[7:0] = {2'h0, chs_q, go_q, en_q};
         end else if (sel == ASC_SEL_TIMING) begin
            prdata_d[7:0] = {fmt_q, 1'b0, acq_q, cs_q};
         end else if (sel == ASC_SEL_RESH) begin
            prdata_d[7:0] = result_q[15:8];
         end else if (sel == ASC_SEL_RESL) begin
            prdata_d[7:0] = result_q[7:0];
         end else if (sel == ASC_SEL_REF) begin
            prdata_d[`ASC_REF_EXT] = refExt_q;
         end else if (sel == ASC_SEL_STAT) begin
            prdata_d[`ASC_STAT_DONE] = flag_q;
         end
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         prdata_q <= 32'h0000_0000;
      end else begin
         prdata_q <= prdata_d;
      end
   end

   assign prdata = prdata_q;

   // ***************************************************
   // Comparator input synchroniser
   // ***************************************************
   always_comb begin
      cmpSync_d = {cmpSync_q[1:0], compIn};
      cmp_d = (cmpSync_q[1] == cmpSync_q[2]) ? cmpSync_q[2] : cmp_q;
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         cmpSync_q <= 3'h0;
         cmp_q <= 1'b0;
      end else begin
         cmpSync_q <= cmpSync_d;
         cmp_q <= cmp_d;
      end
   end

   // ***************************************************
   // Conversion clock
   // ***************************************************
   assign rcSel = (cs_q[1:0] == `ASC_RC_CODE);
   // Main oscillator stops in Sleep, so only the RC source keeps ticking
   assign tadRun = ((state_q == ASC_ACQ) || (state_q == ASC_CONV)) &&
      !(sleepMode && !rcSel);

   asc_tad_gen asc_tad_gen_inst (
      .clock(clock),
      .sys_rst(sys_rst),
      .run(tadRun),
      .clkSel(cs_q),
      .rcOscIn(rcOscIn),
      .tadTick(tadTick)
   );

   // ***************************************************
   // Control registers and sequencer
   // ***************************************************
   always_comb begin
      state_d = state_q;
      en_d = en_q;
      go_d = go_q;
      chs_d = chs_q;
      fmt_d = fmt_q;
      acq_d = acq_q;
      cs_d = cs_q;
      refExt_d = refExt_q;
      result_d = result_q;
      flag_d = flag_q;
      sar_d = sar_q;
      bit_d = bit_q;
      cnt_d = cnt_q;
      convDone = 1'b0;
      sarFinal = sar_q;
      enNow = en_q;
      if (apbWr && (sel == ASC_SEL_CTRL)) begin
         enNow = pwdata[`ASC_CTRL_EN];
         en_d = pwdata[`ASC_CTRL_EN];
         chs_d = pwdata[`ASC_CHS_LSB +: 4];
      end
      if (apbWr && (sel == ASC_SEL_TIMING)) begin
         fmt_d = pwdata[`ASC_TIM_FMT];
         acq_d = pwdata[`ASC_ACQ_LSB +: 3];
         cs_d = pwdata[`ASC_CS_LSB +: 3];
      end
      if (apbWr && (sel == ASC_SEL_REF)) begin
         refExt_d = pwdata[`ASC_REF_EXT];
      end
      if (apbWr && (sel == ASC_SEL_RESH)) begin
         result_d[15:8] = pwdata[7:0];
      end
      if (apbWr && (sel == ASC_SEL_RESL)) begin
         result_d[7:0] = pwdata[7:0];
      end
      if (apbWr && (sel == ASC_SEL_STAT) && pwdata[`ASC_STAT_DONE]) begin
         flag_d = 1'b0;
      end
      // Enable must already be on; a start in the same write is dropped
      startReq = en_q && enNow && (state_q == ASC_IDLE) &&
         ((apbWr && (sel == ASC_SEL_CTRL) && pwdata[`ASC_CTRL_GO]) ||
         (specialTrig && (compareMode == `ASC_TRIG_MODE)));
      abort = apbWr && (sel == ASC_SEL_CTRL) && !pwdata[`ASC_CTRL_GO] &&
         go_q;
      case (state_q)
         ASC_IDLE: begin
            if (startReq) begin
               go_d = 1'b1;
               cnt_d = 5'h00;
               sar_d = `ASC_SAR_MSB; // Comparator settles during hold
               if ((acq_q == 3'h0) || rcSel) begin
                  state_d = ASC_HOLD;
               end else begin
                  state_d = ASC_ACQ;
               end
            end
         end
         ASC_HOLD: begin
            if (cnt_q[3:0] == TCY_LAST) begin
               cnt_d = 5'h00;
               if (acqPeriods(acq_q) == 5'h00) begin
                  state_d = ASC_CONV;
                  sar_d = `ASC_SAR_MSB;
                  bit_d = 4'hb;
               end else begin
                  state_d = ASC_ACQ;
               end
            end else begin
               cnt_d = 5'(cnt_q + 5'h01);
            end
         end
         ASC_ACQ: begin
            if (tadTick) begin
               cnt_d = 5'(cnt_q + 5'h01);
            end
            if (cnt_q >= acqPeriods(acq_q)) begin
               state_d = ASC_CONV;
               sar_d = `ASC_SAR_MSB;
               bit_d = 4'hb;
            end
         end
         ASC_CONV: begin
            if (tadTick) begin
               if (!cmp_q) begin
                  sar_d[bit_q] = 1'b0;
               end
               if (bit_q == 4'h0) begin
                  convDone = 1'b1;
                  sarFinal = sar_d;
               end else begin
                  sar_d[4'(bit_q - 4'h1)] = 1'b1;
                  bit_d = 4'(bit_q - 4'h1);
               end
            end
         end
         ASC_WAIT: begin
            if (cnt_q[3:0] == POST_LAST) begin
               state_d = ASC_IDLE;
               cnt_d = 5'h00;
            end else begin
               cnt_d = 5'(cnt_q + 5'h01);
            end
         end
         default: begin
            state_d = ASC_IDLE;
         end
      endcase
      if (convDone) begin
         // Completion outranks a software write to the result pair
         result_d = fmt_q ? {4'h0, sarFinal} : {sarFinal, 4'h0};
         flag_d = 1'b1;
         go_d = 1'b0;
         state_d = ASC_WAIT;
         cnt_d = 5'h00;
      end
      if (abort) begin
         go_d = 1'b0;
         result_d = result_q;
         if (apbWr && (sel == ASC_SEL_RESH)) begin
            result_d[15:8] = pwdata[7:0];
         end
         if (apbWr && (sel == ASC_SEL_RESL)) begin
            result_d[7:0] = pwdata[7:0];
         end
         flag_d = flag_q && !(apbWr && (sel == ASC_SEL_STAT) &&
            pwdata[`ASC_STAT_DONE]);
         state_d = ASC_WAIT;
         cnt_d = 5'h00;
      end
      if (!enNow) begin
         state_d = ASC_IDLE;
         go_d = 1'b0;
         cnt_d = 5'h00;
      end
      afe_d.channel = chs_d;
      afe_d.channelValid = (chs_d <= `ASC_CHAN_MAX);
      afe_d.sampleOn = enNow && ((state_d == ASC_IDLE) ||
         (state_d == ASC_ACQ) || (state_d == ASC_HOLD));
      afe_d.refExternal = refExt_d;
      afe_d.trialCode = sar_d;
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= ASC_IDLE;
         en_q <= 1'b0;
         go_q <= 1'b0;
         chs_q <= 4'h0;
         fmt_q <= 1'b0;
         acq_q <= 3'h0;
         cs_q <= 3'h0;
         refExt_q <= 1'b0;
         result_q <= `ASC_RESULT_RST;
         flag_q <= 1'b0;
         sar_q <= 12'h000;
         bit_q <= 4'h0;
         cnt_q <= 5'h00;
         afe_q <= '0;
      end else begin
         state_q <= state_d;
         en_q <= en_d;
         go_q <= go_d;
         chs_q <= chs_d;
         fmt_q <= fmt_d;
         acq_q <= acq_d;
         cs_q <= cs_d;
         refExt_q <= refExt_d;
         result_q <= result_d;
         flag_q <= flag_d;
         sar_q <= sar_d;
         bit_q <= bit_d;
         cnt_q <= cnt_d;
         afe_q <= afe_d;
      end
   end

   assign afeCtrl = afe_q;
   assign doneFlag = flag_q;

   // ***************************************************
   // Checks
   // ***************************************************
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);

   property p_runMatchesState;
      (state_q == ASC_IDLE || state_q == ASC_WAIT) == !go_q;
   endproperty
   a_runMatchesState: assert property (p_runMatchesState)
      else $error("run bit disagrees with sequencer state");

   property p_offIsIdle;
      !en_q |-> (state_q == ASC_IDLE) && !go_q && !$rose(go_q);
   endproperty
   a_offIsIdle: assert property (p_offIsIdle)
      else $error("disabled converter is not idle");

   property p_reservedZero;
      (psel && penable && !pwrite && paddr == `ASC_OFS_CTRL) |->
         prdata[7:6] == 2'h0;
   endproperty
   a_reservedZero: assert property (p_reservedZero)
      else $error("reserved control bits read nonzero");

   property p_doneLoads;
      convDone |=> flag_q && !go_q && state_q == ASC_WAIT &&
         (fmt_q ? result_q[15:12] == 4'h0 : result_q[3:0] == 4'h0);
   endproperty
   a_doneLoads: assert property (p_doneLoads)
      else $error("completion did not load result and flag");

   property p_zeroAcqHold;
      (startReq && acq_q == 3'h0 && !rcSel) |=>
         (state_q == ASC_HOLD)[*4] ##1 (state_q == ASC_CONV);
   endproperty
   a_zeroAcqHold: assert property (p_zeroAcqHold)
      else $error("zero acquisition hold-off is not one cycle");

   property p_postWait;
      ($rose(state_q == ASC_WAIT) && en_q && !(apbWr &&
         sel == ASC_SEL_CTRL)) |-> (state_q == ASC_WAIT)[*8] ##1
         (state_q == ASC_IDLE);
   endproperty
   a_postWait: assert property (p_postWait)
      else $error("post-conversion wait has wrong length");

   property p_trigIgnored;
      (specialTrig && !en_q && !go_q) |=> !go_q;
   endproperty
   a_trigIgnored: assert property (p_trigIgnored)
      else $error("trigger started a disabled converter");

   property p_abortKeeps;
      (abort && !(apbWr && (sel == ASC_SEL_RESH || sel == ASC_SEL_RESL)))
         |=> result_q == $past(result_q) && !go_q;
   endproperty
   a_abortKeeps: assert property (p_abortKeeps)
      else $error("abort changed the result pair");

   property p_msbFirst;
      $rose(state_q == ASC_CONV) |-> sar_q == `ASC_SAR_MSB && bit_q == 4'hb;
   endproperty
   a_msbFirst: assert property (p_msbFirst)
      else $error("approximation does not start at the top bit");

endmodule
`default_nettype wire

/* File: tb/asc_adc_ctrl_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "asc_cfg.svh"

module asc_adc_ctrl_tb;

   // ********************************
   // Signals
   // ********************************
   logic clock, sys_rst, psel, penable, pwrite, pready, pslverr;
   logic compIn, rcOscIn, specialTrig, sleepMode, doneFlag;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] compareMode, rcCnt;
   asc_pkg::asc_afe_t afeCtrl;
   logic [32:0] expQ[$];
   logic [32:0] monE;
   logic [11:0] target;
   int fail_count, n_checks, seed, n;
   int divTab[8] = '{2, 8, 32, 12, 4, 16, 64, 12};
   int acqTab[8] = '{0, 2, 4, 6, 8, 12, 16, 20};

   asc_adc_ctrl asc_adc_ctrl_inst (.clock(clock), .sys_rst(sys_rst),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .compIn(compIn), .rcOscIn(rcOscIn),
      .specialTrig(specialTrig), .compareMode(compareMode),
      .sleepMode(sleepMode), .afeCtrl(afeCtrl), .doneFlag(doneFlag));

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // Free-running RC source, period 12 clocks; comparator follows trial
   always @(posedge clock) begin
      rcCnt <= (rcCnt == 4'h5) ? 4'h0 : rcCnt + 4'h1;
      if (rcCnt == 4'h5) rcOscIn <= ~rcOscIn;
      compIn <= (target >= afeCtrl.trialCode);
   end

   // ********************************
   // Checking
   // ********************************
   task check(input logic [32:0] seen, input logic [32:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   task stop_test();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Read data and error flag judged at the completing edge
   always @(posedge clock) begin
      if (psel && penable && pready && !pwrite) begin
         if (expQ.size() == 0) begin
            fail_count++;
            $display("wrong value at %0t: unexpected read", $time);
         end else begin
            monE = expQ.pop_front();
            check({pslverr, prdata}, monE);
         end
      end
   end

   // ********************************
   // Bus tasks
   // ********************************
   task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int k;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clock);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (pready !== 1'b1) begin
         fail_count++;
         stop_test();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
   endtask

   task rd(input logic [7:0] a, input logic [31:0] d, input logic err);
      expQ.push_back({err, d});
      apb(a, 1'b0, 32'h0);
   endtask

   // Sel 0 watches the sampling switch, sel 1 the done flag
   task waitSig(input logic s, input logic lvl, output int c);
      c = 0;
      do begin
         @(posedge clock);
         #1;
         c++;
      end while (((s ? doneFlag : afeCtrl.sampleOn) !== lvl) && c < 5000);
      if (c >= 5000) begin
         fail_count++;
         stop_test();
      end
   endtask

   task pulse();
      @(posedge clock);
      specialTrig <= 1'b1;
      @(posedge clock);
      specialTrig <= 1'b0;
   endtask

   // Fast clocks outrun the comparator sync, so only rail inputs there
   task conv(input logic [2:0] cs, input logic [2:0] acq, input logic fmt,
             input logic [3:0] ch);
      int c, lo, dv, rc;
      logic [15:0] res;
      dv = divTab[cs];
      target = (dv < 8) ? {12{fmt}} : 12'($random(seed));
      rc = (cs[1:0] == 2'h3);
      wr(`ASC_OFS_TIMING, {24'h0, fmt, 1'b0, acq, cs});
      sleepMode <= rc[0];
      wr(`ASC_OFS_CTRL, {26'h0, ch, 2'b01});
      wr(`ASC_OFS_CTRL, {26'h0, ch, 2'b11});
      waitSig(1'b0, 1'b0, c);
      lo = (acqTab[acq] - rc) * dv + ((acq == 0 || rc != 0) ? 4 : 0);
      check(c >= lo && c <= lo + dv + 12, 1'b1);
      waitSig(1'b1, 1'b1, c);
      check(c >= 11 * dv && c <= 12 * dv + 12, 1'b1);
      waitSig(1'b0, 1'b1, c);
      check(c >= 7 && c <= 10, 1'b1);
      res = fmt ? {4'h0, target} : {target, 4'h0};
      rd(`ASC_OFS_CTRL, {26'h0, ch, 2'b01}, 1'b0);
      rd(`ASC_OFS_RESH, {24'h0, res[15:8]}, 1'b0);
      rd(`ASC_OFS_RESL, {24'h0, res[7:0]}, 1'b0);
      check(doneFlag, 1'b1);
      wr(`ASC_OFS_STAT, 32'h1);
      sleepMode <= 1'b0;
      #1;
      check(doneFlag, 1'b0);
   endtask

   // ********************************
   // Sequence
   // ********************************
   initial begin
      seed = 32'hafc5;
      sys_rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      specialTrig = 1'b0;
      compareMode = 4'h0;
      sleepMode = 1'b0;
      rcOscIn = 1'b0;
      rcCnt = 4'h0;
      target = 12'h000;
      fail_count = 0;
      n_checks = 0;
      repeat (12) @(posedge clock);
      sys_rst <= 1'b0;
      rd(`ASC_OFS_CTRL, 32'h0, 1'b0);
      rd(`ASC_OFS_TIMING, 32'h0, 1'b0);
      rd(`ASC_OFS_RESH, 32'h0, 1'b0);
      rd(8'h20, 32'h0, 1'b1);
      wr(`ASC_OFS_CTRL, 32'hff);
      rd(`ASC_OFS_CTRL, 32'h3d, 1'b0);
      check(afeCtrl.channelValid, 1'b0);
      wr(`ASC_OFS_TIMING, 32'hff);
      rd(`ASC_OFS_TIMING, 32'hbf, 1'b0);
      for (int c = 0; c < 16; c++) begin
         wr(`ASC_OFS_CTRL, {26'h0, 4'(c), 2'b01});
         repeat (2) @(posedge clock);
         #1;
         check({afeCtrl.channel, afeCtrl.channelValid},
               {4'(c), c <= 12});
      end
      wr(`ASC_OFS_REF, 32'h1);
      rd(`ASC_OFS_REF, 32'h1, 1'b0);
      check(afeCtrl.refExternal, 1'b1);
      wr(`ASC_OFS_REF, 32'h0);
      for (int i = 0; i < 8; i++) begin
         conv(3'(i), 3'(i), i[0], 4'(i + 5));
      end
      wr(`ASC_OFS_RESH, 32'h5a);
      wr(`ASC_OFS_RESL, 32'ha5);
      wr(`ASC_OFS_TIMING, 32'h3e);
      wr(`ASC_OFS_CTRL, 32'h09);
      pulse();
      rd(`ASC_OFS_CTRL, 32'h09, 1'b0);
      compareMode <= 4'hb;
      wr(`ASC_OFS_CTRL, 32'h08);
      pulse();
      rd(`ASC_OFS_CTRL, 32'h08, 1'b0);
      wr(`ASC_OFS_CTRL, 32'h09);
      pulse();
      rd(`ASC_OFS_CTRL, 32'h0b, 1'b0);
      waitSig(1'b0, 1'b0, n);
      repeat (100) @(posedge clock);
      wr(`ASC_OFS_CTRL, 32'h09);
      waitSig(1'b0, 1'b1, n);
      check(n >= 7 && n <= 10, 1'b1);
      rd(`ASC_OFS_RESH, 32'h5a, 1'b0);
      rd(`ASC_OFS_RESL, 32'ha5, 1'b0);
      check(doneFlag, 1'b0);
      // Reset in mid-conversion
      wr(`ASC_OFS_CTRL, 32'h0b);
      waitSig(1'b0, 1'b0, n);
      @(posedge clock) sys_rst <= 1'b1;
      repeat (3) @(posedge clock);
      #1;
      check({afeCtrl, doneFlag}, '0);
      @(posedge clock) sys_rst <= 1'b0;
      rd(`ASC_OFS_CTRL, 32'h0, 1'b0);
      rd(`ASC_OFS_TIMING, 32'h0, 1'b0);
      rd(`ASC_OFS_RESH, 32'h0, 1'b0);
      repeat (2) @(posedge clock);
      stop_test();
   end

endmodule

`default_nettype wire
